// ### shared/fwac_map.vh
`ifndef FWAC_MAP_VH
`define FWAC_MAP_VH
// Special function register holding the write redirect controls
`define FWAC_SFR_CTRL        8'hB2
// Bit positions within the control SFR
`define FWAC_CTRL_PWE_BIT    0
`define FWAC_CTRL_MEEN_BIT   1
`define FWAC_CTRL_PSTWR_BIT  2
`define FWAC_CTRL_PEND_BIT   3
// External data address of the key and permission register
`define FWAC_XREG_KEY        16'h2702
// Field positions within the key register
`define FWAC_KEY_MSB         7
`define FWAC_KEY_LSB         4
`define FWAC_RDE_BIT         2
`define FWAC_WRE_BIT         1
// Key value that opens flash modification
`define FWAC_KEY_OPEN        4'h2
// Reset values
`define FWAC_RST_KEY         4'h0
`define FWAC_RST_PWE         1'b0
`define FWAC_RST_PSTWR       1'b0
`endif

// ### rtl/fwac_post_queue.v
`timescale 1ns/1ps
// Single-entry queue for a posted flash byte write
module fwac_post_queue (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Request side
   input  wire        req,
   input  wire        hold,
   input  wire [15:0] req_addr,
   input  wire [7:0]  req_data,
   // Release trigger
   input  wire        busy_fall,
   // Write out
   output reg         wr_stb,
   output reg  [15:0] wr_addr,
   output reg  [7:0]  wr_data,
   output reg         pend
);
   reg [15:0] q_addr_r;                 // Queued address
   reg [7:0]  q_data_r;                 // Queued data

   // -----------------------------------------------------------------
   // Queue and issue
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         pend     <= 1'b0;
         wr_stb   <= 1'b0;
         wr_addr  <= 16'h0000;
         wr_data  <= 8'h00;
         q_addr_r <= 16'h0000;
         q_data_r <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (pend) begin
            // Release on compute busy falling
            if (busy_fall) begin
               pend    <= 1'b0;
               wr_stb  <= 1'b1;
               wr_addr <= q_addr_r;
               wr_data <= q_data_r;
            end
         end else if (req && hold) begin
            // Hold the request
            pend     <= 1'b1;
            q_addr_r <= req_addr;
            q_data_r <= req_data;
         end else if (req) begin
            // Immediate write
            wr_stb  <= 1'b1;
            wr_addr <= req_addr;
            wr_data <= req_data;
         end
      end
   end
endmodule // fwac_post_queue

// ### rtl/fwac_top.v
`timescale 1ns/1ps
`include "fwac_map.vh"
// Behaviour
// R1: Enabled store writes accumulator byte to flash
// R2: Enable clear routes moves to external RAM
// R3: Enable self-clears after each flash byte
// R4: Enable writes ignored while interrupts enabled
// R5: Modification refused unless key equals two
// R6: Read permission is inverse of security lock
// R7: Write permission bit reports flash writability
// R8: Pending flag shown; further writes ignored
// R9: Posted writes wait for compute busy fall; with CE_ENABLED low they go out at once
// R10: Redirected store without key leaves flash
module fwac_top (
   // Clock and reset
   input  wire        SYS_CLK,
   input  wire        RSTN,
   // Core SFR access
   input  wire        SFR_WR,
   input  wire [7:0]  SFR_ADDR,
   input  wire [7:0]  SFR_WDATA,
   output reg  [7:0]  SFR_RDATA,
   // Core external data moves
   input  wire        XMOVE_WR,
   input  wire        XMOVE_RD,
   input  wire [15:0] XMOVE_ADDR,
   input  wire [7:0]  XMOVE_WDATA,
   output reg  [7:0]  XMOVE_RDATA,
   // Core state
   input  wire        INT_ENABLED,
   // Security and compute engine state
   input  wire        SECURITY_LOCK,
   input  wire        CE_ENABLED,
   input  wire        CE_BUSY,
   // External RAM port
   output wire        XRAM_WR,
   output wire        XRAM_RD,
   output wire [15:0] XRAM_ADDR,
   output wire [7:0]  XRAM_WDATA,
   input  wire [7:0]  XRAM_RDATA,
   // Flash write port
   output wire        FLASH_WR,
   output wire [15:0] FLASH_ADDR,
   output wire [7:0]  FLASH_WDATA,
   // Permission indicators
   output wire        FLASH_RD_PERMIT,
   output wire        FLASH_WR_PERMIT
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   reg        pwe_r;                    // Program write redirect
   reg        pstwr_r;                  // Posted write enable
   reg  [3:0] key_r;                    // Flash modify key
   reg        busy_d_r;                 // Delayed compute busy
   wire       key_ok;                   // Key opens modification
   wire       key_sel;                  // Key register addressed
   wire       flash_store;              // Store redirected to flash
   wire       flash_req;                // Store accepted for flash
   wire       pend;                     // Posted write waiting
   wire       busy_fall;                // Compute busy falling edge

   assign key_ok    = (key_r == `FWAC_KEY_OPEN);          // R5
   assign key_sel   = (XMOVE_ADDR == `FWAC_XREG_KEY);
   assign busy_fall = busy_d_r & ~CE_BUSY;
   // Store goes to flash when redirect set
   assign flash_store = XMOVE_WR & pwe_r;                 // R1
   // Key must be open and no posted write waiting
   assign flash_req = flash_store & key_ok & ~pend;       // R10 R8

   // -----------------------------------------------------------------
   // External RAM routing
   // -----------------------------------------------------------------
   // Normal moves go to RAM unless redirected or key register hit
   assign XRAM_WR    = XMOVE_WR & ~pwe_r & ~key_sel;      // R2
   assign XRAM_RD    = XMOVE_RD & ~key_sel;
   assign XRAM_ADDR  = XMOVE_ADDR;
   assign XRAM_WDATA = XMOVE_WDATA;

   // -----------------------------------------------------------------
   // Permission indicators
   // -----------------------------------------------------------------
   assign FLASH_RD_PERMIT = ~SECURITY_LOCK;               // R6
   assign FLASH_WR_PERMIT = ~SECURITY_LOCK & key_ok;      // R7

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   always @(posedge SYS_CLK) begin
      if (!RSTN) begin
         pwe_r    <= `FWAC_RST_PWE;
         pstwr_r  <= `FWAC_RST_PSTWR;
         key_r    <= `FWAC_RST_KEY;
         busy_d_r <= 1'b0;
      end else begin
         busy_d_r <= CE_BUSY;
         // Any store toward flash consumes the enable
         if (flash_store) begin
            pwe_r <= 1'b0;                                // R3
         end else if (SFR_WR && SFR_ADDR == `FWAC_SFR_CTRL &&
                      !INT_ENABLED) begin
            pwe_r <= SFR_WDATA[`FWAC_CTRL_PWE_BIT];       // R4
         end
         // Posted enable is writable regardless of interrupts
         if (SFR_WR && SFR_ADDR == `FWAC_SFR_CTRL) begin
            pstwr_r <= SFR_WDATA[`FWAC_CTRL_PSTWR_BIT];
         end
         // Key register write over external data move
         if (XMOVE_WR && !pwe_r && key_sel) begin
            key_r <= XMOVE_WDATA[`FWAC_KEY_MSB:`FWAC_KEY_LSB];
         end
      end
   end

   // -----------------------------------------------------------------
   // Read data registers
   // -----------------------------------------------------------------
   always @(posedge SYS_CLK) begin
      if (!RSTN) begin
         SFR_RDATA   <= 8'h00;
         XMOVE_RDATA <= 8'h00;
      end else begin
         // Control SFR readback
         if (SFR_ADDR == `FWAC_SFR_CTRL) begin
            SFR_RDATA <= {4'h0, pend, pstwr_r, 1'b0, pwe_r}; // R8
         end else begin
            SFR_RDATA <= 8'h00;
         end
         // Key register or RAM readback
         if (key_sel) begin
            XMOVE_RDATA <= {key_r, 1'b0, FLASH_RD_PERMIT,
                            FLASH_WR_PERMIT, 1'b0};
         end else begin
            XMOVE_RDATA <= XRAM_RDATA;
         end
      end
   end

   // -----------------------------------------------------------------
   // Posted write queue
   // -----------------------------------------------------------------
   fwac_post_queue u_queue (
      .clk       (SYS_CLK),
      .rst_n     (RSTN),
      .req       (flash_req),
      .hold      (pstwr_r & CE_ENABLED),                  // R9
      .req_addr  (XMOVE_ADDR),
      .req_data  (XMOVE_WDATA),
      .busy_fall (busy_fall),
      .wr_stb    (FLASH_WR),
      .wr_addr   (FLASH_ADDR),
      .wr_data   (FLASH_WDATA),
      .pend      (pend)
   );
endmodule // fwac_top

// ### tb/fwac_top_monitor.sv
`timescale 1ns/1ps
module fwac_top_monitor (
   // Clock, reset, core
   input wire        SYS_CLK, RSTN, XMOVE_WR, XMOVE_RD, SECURITY_LOCK,
   input wire [15:0] XMOVE_ADDR,
   input wire [7:0]  XMOVE_WDATA,
   // Watched outputs
   input wire        XRAM_WR, XRAM_RD, FLASH_WR,
   input wire        FLASH_RD_PERMIT, FLASH_WR_PERMIT,
   input wire [15:0] XRAM_ADDR, FLASH_ADDR,
   input wire [7:0]  XRAM_WDATA
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   // Strobe has dropped
   sequence pulse_end_s;
      !FLASH_WR;
   endsequence
   read_permit_a: assert property (FLASH_RD_PERMIT == !SECURITY_LOCK)
      else $error("read permit wrong");
   write_permit_a: assert property (FLASH_WR_PERMIT |-> !SECURITY_LOCK)
      else $error("write permit while locked");
   flash_pulse_a: assert property (FLASH_WR |=> pulse_end_s)
      else $error("flash strobe too long");
   ram_write_a: assert property (XRAM_WR |-> XMOVE_WR &&
      XMOVE_ADDR != 16'h2702) else $error("stray RAM write");
   ram_read_a: assert property (XRAM_RD |-> XMOVE_RD)
      else $error("stray RAM read");
   ram_pass_a: assert property (XRAM_WR |-> XRAM_ADDR == XMOVE_ADDR
      && XRAM_WDATA == XMOVE_WDATA) else $error("RAM address wrong");
   flash_hold_a: assert property (!FLASH_WR |-> $stable(FLASH_ADDR)
      || !$past(RSTN)) else $error("flash address moved");
   reset_quiet_a: assert property (disable iff (1'b0)
      !RSTN |=> !FLASH_WR) else $error("flash write in reset");
endmodule // fwac_top_monitor
bind fwac_top fwac_top_monitor u_mon (.*);

// ### tb/fwac_xram_model.sv
`timescale 1ns/1ps
module fwac_xram_model (
   // Clock and RAM port
   input  wire        clk, wr, rd,
   input  wire [15:0] addr,
   input  wire [7:0]  wdata,
   output wire [7:0]  rdata
);
   reg [7:0] mem_r [0:255]; // Byte store
   // Store on write strobe
   always @(posedge clk) begin
      if (wr) begin
         mem_r[addr[7:0]] <= wdata;
      end
   end
   // Released bus shows inverted data
   assign rdata = rd ? mem_r[addr[7:0]] : ~mem_r[addr[7:0]];
endmodule // fwac_xram_model

// ### tb/fwac_top_test.sv
`timescale 1ns/1ps
module fwac_top_test;
   reg SYS_CLK=0, RSTN=0, SFR_WR=0, XMOVE_WR=0, XMOVE_RD=0;
   reg INT_ENABLED=0, SECURITY_LOCK=0, CE_ENABLED=0, CE_BUSY=0;
   reg [7:0] SFR_ADDR=0, SFR_WDATA=0, XMOVE_WDATA=0;
   reg [15:0] XMOVE_ADDR=0;
   wire [7:0] SFR_RDATA, XMOVE_RDATA, XRAM_RDATA, XRAM_WDATA, FLASH_WDATA;
   wire [15:0] XRAM_ADDR, FLASH_ADDR;
   wire XRAM_WR, XRAM_RD, FLASH_WR, FLASH_RD_PERMIT, FLASH_WR_PERMIT;
   integer num_errors=0, checks_done=0, i;
   fwac_top u_dut (.*);
   fwac_xram_model u_ram (.clk(SYS_CLK), .wr(XRAM_WR), .rd(XRAM_RD),
      .addr(XRAM_ADDR), .wdata(XRAM_WDATA), .rdata(XRAM_RDATA));
   always #5 SYS_CLK = ~SYS_CLK;
   task conclude;
      begin
         if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] got, exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // SFR access, one strobe cycle
   task sfr(input w, input [7:0] a, d);
      begin
         @(posedge SYS_CLK);
         SFR_WR <= w; SFR_ADDR <= a; SFR_WDATA <= d;
         @(posedge SYS_CLK);
         SFR_WR <= 0;
         #1;
      end
   endtask
   // External data move, one strobe cycle
   task xm(input w, r, input [15:0] a, input [7:0] d);
      begin
         @(posedge SYS_CLK);
         XMOVE_WR <= w; XMOVE_RD <= r; XMOVE_ADDR <= a; XMOVE_WDATA <= d;
         @(posedge SYS_CLK);
         XMOVE_WR <= 0; XMOVE_RD <= 0;
         #1;
      end
   endtask
   initial begin
      repeat (10) @(posedge SYS_CLK);
      RSTN <= 1;
      sfr(0, 8'hB2, 0); chk(SFR_RDATA, 8'h00);
      chk(FLASH_RD_PERMIT, 1); chk(FLASH_WR_PERMIT, 0);
      @(posedge SYS_CLK) INT_ENABLED <= 1;
      sfr(1, 8'hB2, 8'h01); sfr(0, 8'hB2, 0); chk(SFR_RDATA, 0);
      @(posedge SYS_CLK) INT_ENABLED <= 0;
      sfr(1, 8'hB2, 8'h01); xm(1, 0, 16'h1234, 8'h5A); chk(FLASH_WR, 0);
      sfr(0, 8'hB2, 0); chk(SFR_RDATA, 0);
      xm(1, 0, 16'h2702, 8'h20); chk(FLASH_WR_PERMIT, 1);
      xm(0, 1, 16'h2702, 0); chk(XMOVE_RDATA, 8'h26);
      sfr(1, 8'hB2, 8'h01); xm(1, 0, 16'h1234, 8'h5A); chk(FLASH_WR, 1);
      chk(FLASH_ADDR, 16'h1234); chk(FLASH_WDATA, 8'h5A);
      sfr(0, 8'hB2, 0); chk(SFR_RDATA, 0);
      xm(1, 0, 16'h0040, 8'h77); chk(FLASH_WR, 0);
      xm(0, 1, 16'h0040, 0); chk(XMOVE_RDATA, 8'h77);
      @(posedge SYS_CLK) {CE_ENABLED, CE_BUSY} <= 2'h3;
      sfr(1, 8'hB2, 8'h05); xm(1, 0, 16'hABCD, 8'hC3); chk(FLASH_WR, 0);
      sfr(0, 8'hB2, 0); chk(SFR_RDATA, 8'h0C);
      sfr(1, 8'hB2, 8'h05); xm(1, 0, 16'h1111, 8'h11); chk(FLASH_WR, 0);
      @(posedge SYS_CLK) CE_BUSY <= 0;
      for (i = 0; i < 8 && FLASH_WR !== 1'b1; i = i + 1) @(posedge SYS_CLK) #1;
      chk(FLASH_WR, 1);
      // A missed release was counted above; skip straight to the verdict
      if (i < 8) begin
         chk(FLASH_ADDR, 16'hABCD); chk(FLASH_WDATA, 8'hC3);
         sfr(0, 8'hB2, 0); chk(SFR_RDATA, 8'h04);
         @(posedge SYS_CLK) SECURITY_LOCK <= 1;
         #1 chk(FLASH_RD_PERMIT, 0); chk(FLASH_WR_PERMIT, 0);
      end
      conclude;
   end
endmodule // fwac_top_test
